// ### hdl/rtrm_remap.sv
// Remote target physical address registers and alias remap
`timescale 1ns/1ps
`default_nettype none
`include "rtrm_defines.svh"
module rtrm_remap
    import rtrm_pkg::*;
#(
    parameter int NUM_PORTS = 4
)
(
    input  wire logic        clk_sys,    // System clock, 100 MHz
    input  wire logic        rst,        // Synchronous reset, high
    input  wire logic [7:0]  reg_addr,   // Register offset
    input  wire logic        reg_wr,     // Write strobe
    input  wire logic        reg_rd,     // Read strobe
    input  wire logic [7:0]  reg_wdata,  // Write data
    output logic      [7:0]  reg_rdata,  // Read data, registered
    output logic             reg_hit,    // Offset belongs to block
    input  wire logic [NUM_PORTS-1:0] port_sel, // Port-select bits
    input  wire logic [1:0]  port_idx,   // Port of this transaction
    input  wire logic        txn_valid,  // Address phase pulse
    input  wire logic [6:0]  txn_addr,   // Incoming 7-bit address
    input  wire logic        txn_write,  // Transaction is a write
    input  wire logic [20:0] alias_cfg,  // Aliases of targets 3..5
    input  wire logic [2:0]  auto_ack,   // Auto-ack of targets 3..5
    output logic             fwd_valid,  // Forward request, one cycle
    output logic      [6:0]  fwd_addr,   // Remapped address
    output logic             fwd_match,  // An alias matched
    output logic             fwd_ack     // Local acknowledge
);

    ////////////////////////////////////////////////////////////////////////
    // Storage: one copy per port and target
    rtrm_addr7_t phys_reg  [NUM_PORTS][`RTRM_NUM_TGT];
    rtrm_addr7_t phys_next [NUM_PORTS][`RTRM_NUM_TGT];
    logic [7:0] rdata_reg, rdata_next;
    logic       fv_reg, fv_next, fm_reg, fm_next, fa_reg, fa_next;
    logic [6:0] fa7_reg, fa7_next;
    logic [1:0] tsel;
    logic       tsel_ok;
    logic [2:0] hits;

    // Decode register offset to target index
    always_comb
    begin
        tsel    = 2'd0;
        tsel_ok = 1'b1;
        if (reg_addr == `RTRM_OFS_TGT3_PHYS)
            tsel = 2'd0;
        else if (reg_addr == `RTRM_OFS_TGT4_PHYS)
            tsel = 2'd1;
        else if (reg_addr == `RTRM_OFS_TGT5_PHYS)
            tsel = 2'd2;
        else
            tsel_ok = 1'b0;
    end
    assign reg_hit = tsel_ok;

    // Writes reach every selected port; reads come from the lowest one
    always_comb
    begin
        phys_next  = phys_reg;
        rdata_next = 8'h00;
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            if (reg_wr && tsel_ok && port_sel[p])
                phys_next[p][tsel] = reg_wdata[`RTRM_ADDR_MSB:`RTRM_ADDR_LSB];
        end
        if (reg_rd && tsel_ok)
        begin
            for (int p = NUM_PORTS - 1; p >= 0; p--)
            begin
                if (port_sel[p])
                    rdata_next = {phys_reg[p][tsel], 1'b0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Alias comparators, one per target
    genvar g;
    generate
        for (g = 0; g < `RTRM_NUM_TGT; g++)
        begin : g_match
            rtrm_match u_match
            (
                .in_addr    (txn_addr),
                .alias_addr (alias_cfg[g*7 +: 7]),
                .hit        (hits[g])
            );
        end
    endgenerate

    // Remap: first matching target wins, untouched address otherwise
    // Two equal aliases are a setup fault; walking down from the top
    // target only makes the choice repeatable, the lowest one wins
    always_comb
    begin
        fv_next  = txn_valid;
        fm_next  = 1'b0;
        fa_next  = 1'b0;
        fa7_next = txn_addr;
        for (int t = `RTRM_NUM_TGT - 1; t >= 0; t--)
        begin
            if (hits[t])
            begin
                fm_next  = 1'b1;
                fa7_next = phys_reg[port_idx][t];
                fa_next  = txn_write && auto_ack[t];
            end
        end
        if (!txn_valid)
        begin
            fm_next = 1'b0;
            fa_next = 1'b0;
        end
    end

    // Register every state group
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            for (int p = 0; p < NUM_PORTS; p++)
                for (int t = 0; t < `RTRM_NUM_TGT; t++)
                    phys_reg[p][t] <= `RTRM_PHYS_RESET;
            rdata_reg <= 8'h00;
            fv_reg    <= 1'b0;
            fm_reg    <= 1'b0;
            fa_reg    <= 1'b0;
            fa7_reg   <= 7'h00;
        end
        else
        begin
            phys_reg  <= phys_next;
            rdata_reg <= rdata_next;
            fv_reg    <= fv_next;
            fm_reg    <= fm_next;
            fa_reg    <= fa_next;
            fa7_reg   <= fa7_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign fwd_valid = fv_reg;
    assign fwd_match = fm_reg;
    assign fwd_ack   = fa_reg;
    assign fwd_addr  = fa7_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_wr3;
        reg_wr && reg_addr == 8'h60 && port_sel[0];
    endsequence
    sequence s_rd3;
        reg_rd && reg_addr == 8'h60 && port_sel == 4'h1;
    endsequence
    AST_WR_RD_T3: assert property (@(posedge clk_sys) disable iff (rst)
        (s_wr3 ##1 (s_rd3 and !reg_wr)) |=>
            reg_rdata == ($past(reg_wdata, 2) & 8'hfe))
        else $error("target 3 readback wrong");
    AST_RESV_ZERO: assert property (@(posedge clk_sys) disable iff (rst)
        reg_rdata[0] == 1'b0)
        else $error("reserved bit not zero");
    AST_UNMAPPED: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_rd && !reg_hit) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_ALIAS_OFF: assert property (@(posedge clk_sys) disable iff (rst)
        (txn_valid && txn_addr == 7'h00) |=> !fwd_match)
        else $error("zero alias matched");
    AST_REMAP: assert property (@(posedge clk_sys) disable iff (rst)
        (txn_valid && hits[0]) |=> fwd_addr == $past(phys_reg[port_idx][0]))
        else $error("remap address wrong");
    AST_PASS: assert property (@(posedge clk_sys) disable iff (rst)
        (txn_valid && hits == 3'b000) |=>
            fwd_valid && !fwd_match && fwd_addr == $past(txn_addr))
        else $error("unmatched address altered");
    AST_AUTOACK: assert property (@(posedge clk_sys) disable iff (rst)
        (txn_valid && txn_write && hits == 3'b100 && auto_ack[2]) |=> fwd_ack)
        else $error("auto acknowledge missing");
    AST_NOACK_RD: assert property (@(posedge clk_sys) disable iff (rst)
        (txn_valid && !txn_write) |=> !fwd_ack)
        else $error("acknowledge on read");
    AST_T4_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
        !(reg_wr && reg_addr == 8'h61) |=> $stable(phys_reg[0][1]))
        else $error("target 4 changed without write");
    AST_T5_WR: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_wr && reg_addr == 8'h62 && port_sel[1]) |=>
            phys_reg[1][2] == $past(reg_wdata[7:1]))
        else $error("target 5 write lost");

    // Idle cycles return zero on the read data bus
    AST_RD_IDLE: assert property (@(posedge clk_sys) disable iff (rst)
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero when idle");

    // A forward request follows every address phase and only those
    AST_FWD_VALID: assert property (@(posedge clk_sys) disable iff (rst)
        txn_valid |=> fwd_valid)
        else $error("forward request missing");
    AST_FWD_IDLE: assert property (@(posedge clk_sys) disable iff (rst)
        !txn_valid |=> !fwd_valid && !fwd_match && !fwd_ack)
        else $error("forward outputs active when idle");

    // An unmatched address never gets a local acknowledge
    AST_NOACK_MISS: assert property (@(posedge clk_sys) disable iff (rst)
        (txn_valid && hits == 3'b000) |=> !fwd_ack)
        else $error("acknowledge without a matching alias");

    // A port left out of the select keeps its copy
    AST_PORT_ISO: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_wr && !port_sel[0]) |=> $stable(phys_reg[0][0]))
        else $error("unselected port copy changed");

    // A write with several ports selected lands in the top one as well
    sequence s_wr5_top;
        reg_wr && reg_addr == `RTRM_OFS_TGT5_PHYS && port_sel[NUM_PORTS-1];
    endsequence
    AST_WR_ALL: assert property (@(posedge clk_sys) disable iff (rst)
        s_wr5_top |=> phys_reg[NUM_PORTS-1][2] == $past(reg_wdata[7:1]))
        else $error("top port copy not written");

    // With port 0 left out and port 1 selected, a read returns the copy of port 1
    AST_RD_LOW: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_rd && reg_hit && !port_sel[0] && port_sel[1]) |=>
            reg_rdata == {$past(phys_reg[1][tsel]), 1'b0})
        else $error("read did not take the lowest port");
endmodule
`default_nettype wire

// ### hdl/rtrm_defines.svh
// Offsets, field positions and reset values of the remote target remap block
// Function
// - Every receive port has its own copy of each target address register, and the port-select register picks which copy a register access reaches.
// - Offset 0x60 holds the 7-bit physical address of remote target 3 in bits 7:1, readable and writable.
// - Offset 0x61 holds the 7-bit physical address of remote target 4 in bits 7:1, readable and writable.
// - Offset 0x62 holds the 7-bit physical address of remote target 5 in bits 7:1, readable and writable.
// - A transaction addressed to a target's alias is forwarded with the target's stored physical address instead.
// - Incoming addresses are compared against the 7-bit alias in bits 7:1, and an alias of zero disables that target.
// - With a target's auto-acknowledge bit set, every write to it is acknowledged whatever the lock or remote acknowledge.
`ifndef RTRM_DEFINES_SVH
`define RTRM_DEFINES_SVH

`define RTRM_OFS_PORT_SEL  8'h4c
`define RTRM_OFS_TGT3_PHYS 8'h60
`define RTRM_OFS_TGT4_PHYS 8'h61
`define RTRM_OFS_TGT5_PHYS 8'h62
`define RTRM_ADDR_MSB      7
`define RTRM_ADDR_LSB      1
`define RTRM_RESV_BIT      0
`define RTRM_PHYS_RESET    7'h00
`define RTRM_ALIAS_OFF     7'h00
`define RTRM_NUM_TGT       3

`endif

// ### hdl/rtrm_pkg.sv
// Types shared by the remote target remap block
`default_nettype none
package rtrm_pkg;
    typedef logic [6:0] rtrm_addr7_t;
    typedef enum logic [1:0] {RTRM_IDLE, RTRM_FWD, RTRM_PASS} rtrm_state_t;
endpackage
`default_nettype wire

// ### hdl/rtrm_match.sv
// Alias comparator for one remote target
`timescale 1ns/1ps
`default_nettype none
`include "rtrm_defines.svh"
module rtrm_match
    import rtrm_pkg::*;
(
    input  wire rtrm_addr7_t in_addr,     // Incoming 7-bit address
    input  wire rtrm_addr7_t alias_addr,  // Alias of the target
    output logic             hit          // Alias matches and is enabled
);
    // Zero alias means the target is switched off
    assign hit = (alias_addr != `RTRM_ALIAS_OFF)
               && (in_addr == alias_addr);
endmodule
`default_nettype wire

// ### tb/rtrm_far_model.sv
// Far-side model: control channel sink for forwarded addresses
`timescale 1ns/1ps
`default_nettype none
module rtrm_far_model
(
    input  wire logic       clk_sys,   // System clock
    input  wire logic       fwd_valid, // Forward request
    input  wire logic [6:0] fwd_addr,  // Remapped address
    output logic      [6:0] last_addr  // Last address carried
);
    // The channel never stalls, so every request is taken at once
    always_ff @(posedge clk_sys)
    begin
        if (fwd_valid)
            last_addr <= fwd_addr;
    end
endmodule
`default_nettype wire

// ### tb/rtrm_remap_test.sv
// Self-checking bench for the remote target remap block
`timescale 1ns/1ps
`default_nettype none
module rtrm_remap_test;
    logic        clk_sys, rst, reg_wr, reg_rd, txn_valid, txn_write;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic [3:0]  port_sel;
    logic [1:0]  port_idx;
    logic [6:0]  txn_addr, fwd_addr, last_addr;
    logic [20:0] alias_cfg;
    logic [2:0]  auto_ack;
    logic        reg_hit, fwd_valid, fwd_match, fwd_ack;
    int          err_count = 0;
    int          n_checks = 0;
    int          cyc = 0;
    // Rows: port select, offset, write data, expected read back
    logic [27:0] rows [5] = '{28'h160fffe, 28'h161a5a4, 28'h1625b5a,
                              28'h2603332, 28'he624444};
    ////////////////////////////////////////////////////////////
    rtrm_remap #(.NUM_PORTS(4)) DUT (.clk_sys, .rst, .reg_addr, .reg_wr,
        .reg_rd, .reg_wdata, .reg_rdata, .reg_hit, .port_sel, .port_idx,
        .txn_valid, .txn_addr, .txn_write, .alias_cfg, .auto_ack,
        .fwd_valid, .fwd_addr, .fwd_match, .fwd_ack);
    rtrm_far_model far (.clk_sys, .fwd_valid, .fwd_addr, .last_addr);
    ////////////////////////////////////////////////////////////
    // Free-running system clock
    initial
    begin
        clk_sys = 0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One register access, launched at an edge; calls may run back to back
    task automatic acc(input logic [3:0] ps, input logic [7:0] a, d,
                       input logic w);
        @(posedge clk_sys);
        port_sel  <= ps;
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= w;
        reg_rd    <= !w;
    endtask
    // One address phase, launched at an edge
    task automatic txn(input logic [1:0] p, input logic [6:0] a,
                       input logic w);
        @(posedge clk_sys);
        port_idx  <= p;
        txn_addr  <= a;
        txn_write <= w;
        txn_valid <= 1;
    endtask
    // Drop the strobes; the answer to the last request stands on return
    task automatic idle();
        @(posedge clk_sys);
        reg_wr    <= 0;
        reg_rd    <= 0;
        txn_valid <= 0;
        #1;
    endtask
    task automatic finish_test();
        if (err_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    // Hang guard: the whole run needs well under 200 cycles
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 1000)
        begin
            err_count++;
            finish_test();
        end
    end
    // Target 5 alias starts at zero, so it is unreachable until set
    initial
    begin
        {rst, reg_wr, reg_rd, txn_valid, txn_write} = 5'h10;
        {reg_addr, reg_wdata, port_sel, port_idx, txn_addr} = 0;
        alias_cfg = {7'h00, 7'h11, 7'h10};
        auto_ack = 3'b001;
        repeat (10) @(posedge clk_sys);
        rst <= 0;
        acc(4'h1, 8'h60, 8'h00, 0);
        idle();
        chk(reg_rdata, 8'h00);
        foreach (rows[i])
        begin
            acc(rows[i][27:24], rows[i][23:16], rows[i][15:8], 1);
            acc(rows[i][27:24], rows[i][23:16], 8'h00, 0);
            idle();
            chk(reg_rdata, rows[i][7:0]);
            chk({7'h00, reg_hit}, 8'h01);
        end
        acc(4'h1, 8'h60, 8'h00, 0);
        idle();
        chk(reg_rdata, 8'hfe);
        acc(4'h8, 8'h62, 8'h00, 0);
        idle();
        chk(reg_rdata, 8'h44);
        acc(4'h1, 8'h63, 8'h77, 1);
        acc(4'h1, 8'h63, 8'h00, 0);
        idle();
        chk(reg_rdata, 8'h00);
        chk({7'h00, reg_hit}, 8'h00);
        txn(2'd1, 7'h10, 1);
        idle();
        chk({fwd_valid, fwd_addr}, 8'h99);
        chk({6'h0, fwd_match, fwd_ack}, 8'h03);
        txn(2'd0, 7'h11, 0);
        idle();
        chk({fwd_valid, fwd_addr}, 8'hd2);
        chk({6'h0, fwd_match, fwd_ack}, 8'h02);
        chk({1'b0, last_addr}, 8'h19);
        txn(2'd0, 7'h00, 1);
        idle();
        chk({fwd_valid, fwd_addr}, 8'h80);
        chk({6'h0, fwd_match, fwd_ack}, 8'h00);
        // Switch target 5 on with auto-acknowledge
        @(posedge clk_sys);
        alias_cfg <= {7'h12, 7'h11, 7'h10};
        auto_ack  <= 3'b101;
        txn(2'd2, 7'h12, 1);
        idle();
        chk({fwd_valid, fwd_addr}, 8'ha2);
        chk({6'h0, fwd_match, fwd_ack}, 8'h03);
        // Reset in mid-run brings every copy back to zero
        @(posedge clk_sys);
        rst <= 1;
        repeat (2) @(posedge clk_sys);
        rst <= 0;
        acc(4'h2, 8'h60, 8'h00, 0);
        idle();
        chk(reg_rdata, 8'h00);
        chk({fwd_valid, fwd_addr}, 8'h00);
        finish_test();
    end
endmodule
`default_nettype wire
